// [rtl/ssec_eeprom.sv]
// Notes on behaviour
// - Only modes 0,0 and 1,1 are supported.
// - Array holds 4096 bytes, reached by serial commands.
// - Opcode shifts into 8-bit register on rising clock.
// - All bytes travel most significant bit first.
// - First bit taken on first rise after select.
// - Hold freezes clock and data inputs, not chip select.
// - Releasing hold resumes exactly where it stopped.
// - No internal write without write enable latch.
// - Latch clears at reset and after writes, clear.
// - 06h sets latch, 04h clears latch.
// - 05h reads status, 01h writes protection bits.
// - 03h reads array, 02h writes; address follows.
// - Status read works even during internal write.
// - Status bit 0 is busy, read only.
// - Clear latch blocks array and status writes.
// - Status bit 1 mirrors latch, always updatable.
// - Guard bits 3:2 change only by status write.
// - Status bit 7 enables the protect pin.
// - Pin protection needs pin low and enable set.
// - Pin protection blocks only status bit writes.
// - Internal write starts at select rise, 5 ms.
// - Guard codes protect none, top quarter, half, all.
// - Read ignores upper address bits, wraps at top.
// - Write up to 32 bytes, wraps within page.
// - Output changes after fall, input taken on rise.
`timescale 1ns/1ps
`default_nettype none
module ssec_eeprom #(
  parameter int WR_CYCLES = ssec_pkg::WR_CYCLES,
  parameter int FIFO_DEPTH = 2
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic protect_pin_n,
  output logic so_o,
  output logic so_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [1:0] si_s;
    logic [1:0] hold_s;
    logic [1:0] wp_s;
    ssec_pkg::ssec_state_t st;
    logic [2:0] cnt;
    logic [6:0] sh;
    logic [7:0] op;
    logic addr_hi;
    logic [11:0] addr;
    logic seen;
    logic [7:0] sw;
    logic [7:0] out;
    logic so;
    logic so_oe;
    logic latch;
    logic pin_en;
    logic [1:0] guard;
    logic busy;
    logic arr_wr;
    logic [ssec_pkg::TIMER_W-1:0] timer;
    logic [ssec_pkg::PAGE_W:0] cidx;
    logic [ssec_pkg::PAGE_BYTES-1:0] mask;
    logic [11:0] rd_addr;
  } ssec_st_t;

  ssec_st_t q, d;

  logic [7:0] mem_q [ssec_pkg::ARRAY_BYTES];
  logic [7:0] pg_q [ssec_pkg::PAGE_BYTES];

  logic rise, fall, cs_rise, last, hw_prot, fifo_flush;
  logic pg_we, mem_we;
  logic [7:0] byte_in, status;
  logic [11:0] mem_wa;

  ssec_stream_if #(.W(8)) rd_push ();
  ssec_stream_if #(.W(8)) rd_pop ();

  ////////////////////////////////////////////////////////////////////////////
  // Read-ahead buffer, so a slow shifter stalls the prefetch

  ssec_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(mclk),
    .rst(sys_rst),
    .flush(fifo_flush),
    .push(rd_push),
    .pop(rd_pop)
  );

  assign rd_push.valid = (q.st == ssec_pkg::SSEC_RDOUT) & ~fifo_flush;
  assign rd_push.data = mem_q[q.rd_addr];
  assign rd_pop.ready = rise & last & (q.st == ssec_pkg::SSEC_RDOUT);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic guarded(input logic [1:0] g, input logic [11:0] a);
    logic r;
    r = 1'b1;
    case (g)
      ssec_pkg::GUARD_NONE: r = 1'b0;
      ssec_pkg::GUARD_QUART: r = (a >= ssec_pkg::GUARD_QUART_BASE);
      ssec_pkg::GUARD_HALF: r = (a >= ssec_pkg::GUARD_HALF_BASE);
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  always_comb begin
    status = '0;
    status[ssec_pkg::SR_BUSY] = q.busy;
    status[ssec_pkg::SR_LATCH] = q.latch;
    status[ssec_pkg::SR_GUARD_HI:ssec_pkg::SR_GUARD_LO] = q.guard;
    status[ssec_pkg::SR_PIN_EN-1:ssec_pkg::SR_GUARD_HI+1] = ssec_pkg::SR_SPARE_VAL;
    status[ssec_pkg::SR_PIN_EN] = q.pin_en;
  end

  // Edges seen on the second sync stage; hold gates them
  assign rise = q.sck_s[1] & ~q.sck_s[2] & ~q.cs_s[1] & q.hold_s[1];
  assign fall = ~q.sck_s[1] & q.sck_s[2] & ~q.cs_s[1] & q.hold_s[1];
  assign cs_rise = q.cs_s[1] & ~q.cs_s[2];
  assign last = (q.cnt == 3'h7);
  assign byte_in = {q.sh, q.si_s[1]};
  assign hw_prot = ~q.wp_s[1] & q.pin_en;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    pg_we = 1'b0;
    mem_we = 1'b0;
    fifo_flush = 1'b0;
    mem_wa = {q.addr[11:ssec_pkg::PAGE_W], q.cidx[ssec_pkg::PAGE_W-1:0]};
    d.sck_s = {q.sck_s[1:0], sck};
    d.cs_s = {q.cs_s[1:0], cs_n};
    d.si_s = {q.si_s[0], si};
    d.hold_s = {q.hold_s[0], hold_n};
    d.wp_s = {q.wp_s[0], protect_pin_n};

    if (rd_push.valid & rd_push.ready) begin
      d.rd_addr = q.rd_addr + 12'h1;
    end

    // Input shifting on rising edges only
    if (rise) begin
      d.sh = byte_in[6:0];
      d.cnt = q.cnt + 3'h1;
      if (!last && q.st == ssec_pkg::SSEC_WDATA) begin
        d.seen = q.seen;
      end
      if (last) begin
        case (q.st)
          ssec_pkg::SSEC_OPC: begin
            d.op = byte_in;
            case (byte_in)
              ssec_pkg::OP_LATCH_SET, ssec_pkg::OP_LATCH_CLR: begin
                d.st = ssec_pkg::SSEC_DONE;
              end
              ssec_pkg::OP_ARR_RD, ssec_pkg::OP_ARR_WR: begin
                d.st = q.busy ? ssec_pkg::SSEC_IGNORE : ssec_pkg::SSEC_ADDR;
                d.addr_hi = 1'b1;
              end
              ssec_pkg::OP_STAT_RD: begin
                d.st = ssec_pkg::SSEC_SROUT;
                d.out = status;
              end
              ssec_pkg::OP_STAT_WR: begin
                d.st = q.busy ? ssec_pkg::SSEC_IGNORE : ssec_pkg::SSEC_SWDATA;
              end
              default: begin
                d.st = ssec_pkg::SSEC_IGNORE;
              end
            endcase
          end
          ssec_pkg::SSEC_ADDR: begin
            if (q.addr_hi) begin
              d.addr[11:8] = byte_in[3:0];
              d.addr_hi = 1'b0;
            end else begin
              d.addr[7:0] = byte_in;
              if (q.op == ssec_pkg::OP_ARR_RD) begin
                // First byte read directly; the buffer prefetches the rest
                d.st = ssec_pkg::SSEC_RDOUT;
                d.out = mem_q[{q.addr[11:8], byte_in}];
                d.rd_addr = {q.addr[11:8], byte_in} + 12'h1;
                fifo_flush = 1'b1;
              end else begin
                d.st = ssec_pkg::SSEC_WDATA;
                d.mask = '0;
                d.seen = 1'b0;
              end
            end
          end
          ssec_pkg::SSEC_WDATA: begin
            pg_we = 1'b1;
            d.mask[q.addr[ssec_pkg::PAGE_W-1:0]] = 1'b1;
            d.addr[ssec_pkg::PAGE_W-1:0] = q.addr[ssec_pkg::PAGE_W-1:0] + 5'h1;
            d.seen = 1'b1;
          end
          ssec_pkg::SSEC_RDOUT: begin
            d.out = rd_pop.valid ? rd_pop.data : 8'h00;
          end
          ssec_pkg::SSEC_SROUT: begin
            d.out = status;
          end
          ssec_pkg::SSEC_SWDATA: begin
            d.sw = byte_in;
            d.st = ssec_pkg::SSEC_DONE;
          end
          default: begin
            d.st = ssec_pkg::SSEC_IGNORE;
          end
        endcase
      end
    end

    // Output shifting after falling edges
    if (fall && (q.st == ssec_pkg::SSEC_RDOUT || q.st == ssec_pkg::SSEC_SROUT)) begin
      d.so = q.out[7];
      d.out = {q.out[6:0], 1'b0};
    end
    d.so_oe = (q.st == ssec_pkg::SSEC_RDOUT || q.st == ssec_pkg::SSEC_SROUT) & ~q.cs_s[1] & q.hold_s[1];

    // Self-timed write; array bytes committed one per cycle at its start
    if (q.busy) begin
      d.timer = q.timer + ssec_pkg::TIMER_W'(1);
      if (q.arr_wr && !q.cidx[ssec_pkg::PAGE_W]) begin
        mem_we = q.mask[q.cidx[ssec_pkg::PAGE_W-1:0]];
        d.cidx = q.cidx + 6'h1;
      end
      if (q.timer == ssec_pkg::TIMER_W'(WR_CYCLES - 1)) begin
        d.busy = 1'b0;
        d.latch = 1'b0;
      end
    end

    // Deselect ends any sequence; a clean end executes it
    if (q.cs_s[1]) begin
      d.st = ssec_pkg::SSEC_OPC;
      d.cnt = '0;
    end
    if (cs_rise && q.cnt == 3'h0) begin
      if (q.st == ssec_pkg::SSEC_DONE && q.op == ssec_pkg::OP_LATCH_SET) begin
        d.latch = 1'b1;
      end
      if (q.st == ssec_pkg::SSEC_DONE && q.op == ssec_pkg::OP_LATCH_CLR) begin
        d.latch = 1'b0;
      end
      if (q.st == ssec_pkg::SSEC_DONE && q.op == ssec_pkg::OP_STAT_WR && q.latch && !hw_prot && !q.busy) begin
        d.pin_en = q.sw[ssec_pkg::SR_PIN_EN];
        d.guard = q.sw[ssec_pkg::SR_GUARD_HI:ssec_pkg::SR_GUARD_LO];
        d.busy = 1'b1;
        d.arr_wr = 1'b0;
        d.timer = '0;
      end
      // Guard regions are page aligned, so the page base decides
      if (q.st == ssec_pkg::SSEC_WDATA && q.seen && q.latch && !q.busy && !guarded(q.guard, q.addr)) begin
        d.busy = 1'b1;
        d.arr_wr = 1'b1;
        d.timer = '0;
        d.cidx = '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      q <= '0;
      q.sck_s <= 3'h0;
      q.cs_s <= 3'h7;
      q.hold_s <= 2'h3;
      q.wp_s <= 2'h3;
      q.st <= ssec_pkg::SSEC_OPC;
      q.guard <= ssec_pkg::GUARD_RST;
      q.pin_en <= ssec_pkg::PIN_EN_RST;
      q.latch <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Memories carry no reset; they stand for nonvolatile cells
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem_q[mem_wa] <= pg_q[q.cidx[ssec_pkg::PAGE_W-1:0]];
    end
  end

  always_ff @(posedge mclk) begin
    if (pg_we) begin
      pg_q[q.addr[ssec_pkg::PAGE_W-1:0]] <= byte_in;
    end
  end

  assign so_o = q.so;
  assign so_oe = q.so_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_set_end;
    cs_rise && q.cnt == 3'h0 && q.st == ssec_pkg::SSEC_DONE && q.op == ssec_pkg::OP_LATCH_SET;
  endsequence

  sequence s_status_read_cmd_cmd;
    rise && last && q.st == ssec_pkg::SSEC_OPC && byte_in == ssec_pkg::OP_STAT_RD;
  endsequence

  sequence s_blocked_write;
    cs_rise && q.cnt == 3'h0 && q.st == ssec_pkg::SSEC_WDATA && !q.busy && (!q.latch || guarded(q.guard, q.addr));
  endsequence

  a_latch_set: assert property (s_set_end |=> q.latch)
    else $error("latch not set after set command");
  a_latch_partial: assert property (cs_rise && q.cnt != 3'h0 && !q.busy |=> q.latch == $past(q.latch))
    else $error("latch moved on broken sequence");
  a_status_load: assert property (s_status_read_cmd_cmd |=> q.st == ssec_pkg::SSEC_SROUT && q.out == $past(status))
    else $error("status not loaded for read");
  a_write_block: assert property (s_blocked_write |=> !q.busy)
    else $error("blocked write started");
  a_pin_guard: assert property (cs_rise && q.st == ssec_pkg::SSEC_DONE && q.op == ssec_pkg::OP_STAT_WR
    && hw_prot |=> q.pin_en == $past(q.pin_en) && q.guard == $past(q.guard))
    else $error("protected status bits changed");
  a_busy_end: assert property (q.busy && q.timer == ssec_pkg::TIMER_W'(WR_CYCLES - 1) |=> !q.busy && !q.latch)
    else $error("write cycle did not end cleanly");
  a_hold_freeze: assert property (!q.hold_s[1] && !q.cs_s[1] |=> q.cnt == $past(q.cnt) && q.sh == $past(q.sh))
    else $error("shifter moved during hold");
  a_so_quiet: assert property (q.cs_s[1] |=> ##1 !so_oe)
    else $error("output driven while deselected");
  a_so_step: assert property (fall && q.st == ssec_pkg::SSEC_SROUT |=> so_o == $past(q.out[7]))
    else $error("output bit order wrong");

endmodule // ssec_eeprom
`default_nettype wire

// [rtl/ssec_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module ssec_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  ssec_stream_if.snk push,
  ssec_stream_if.src pop
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] ent;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } ssec_fifo_st_t;

  ssec_fifo_st_t q, d;
  logic do_push, do_pop;

  assign push.ready = (q.cnt != (PW+1)'(DEPTH));
  assign pop.valid = (q.cnt != '0);
  assign pop.data = q.ent[q.rp];

  always_comb begin
    d = q;
    do_push = push.valid & push.ready;
    do_pop = pop.valid & pop.ready;
    if (flush) begin
      d.wp = '0;
      d.rp = '0;
      d.cnt = '0;
    end else begin
      if (do_push) begin
        d.ent[q.wp] = push.data;
        d.wp = (q.wp == PW'(DEPTH-1)) ? '0 : q.wp + PW'(1);
      end
      if (do_pop) begin
        d.rp = (q.rp == PW'(DEPTH-1)) ? '0 : q.rp + PW'(1);
      end
      d.cnt = q.cnt + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Count tracks each push and pop handshake in every cycle without a flush
  a_fifo_count: assert property (!flush |=> q.cnt == $past(q.cnt) + (PW+1)'($past(do_push)) - (PW+1)'($past(do_pop)))
    else $error("fifo count mismatch");
endmodule // ssec_fifo
`default_nettype wire

// [rtl/ssec_pkg.sv]
package ssec_pkg;

  // Array geometry
  localparam int ARRAY_BYTES = 4096;
  localparam int ADDR_W = 12;
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_W = 5;

  // Opcodes
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_ARR_RD = 8'h03;
  localparam logic [7:0] OP_ARR_WR = 8'h02;

  // Status register layout
  localparam int SR_BUSY = 0;
  localparam int SR_LATCH = 1;
  localparam int SR_GUARD_LO = 2;
  localparam int SR_GUARD_HI = 3;
  localparam int SR_PIN_EN = 7;
  localparam logic [2:0] SR_SPARE_VAL = 3'h0;
  localparam logic [1:0] GUARD_RST = 2'h0;
  localparam logic PIN_EN_RST = 1'b0;

  // Guard region bounds
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_QUART = 2'h1;
  localparam logic [1:0] GUARD_HALF = 2'h2;
  localparam logic [11:0] GUARD_QUART_BASE = 12'hc00;
  localparam logic [11:0] GUARD_HALF_BASE = 12'h800;

  // Self-timed write, longest time rounded down
  localparam int WR_TIME_MS = 5;
  localparam int CLK_KHZ = 125000;
  localparam int WR_CYCLES = WR_TIME_MS * CLK_KHZ;
  localparam int TIMER_W = 20;

  // Command sequence states
  typedef enum logic [2:0] {
    SSEC_OPC = 3'b000,
    SSEC_ADDR = 3'b001,
    SSEC_WDATA = 3'b010,
    SSEC_RDOUT = 3'b011,
    SSEC_SROUT = 3'b100,
    SSEC_SWDATA = 3'b101,
    SSEC_DONE = 3'b110,
    SSEC_IGNORE = 3'b111
  } ssec_state_t;

endpackage

// [rtl/ssec_stream_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ssec_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [verif/ssec_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ssec_host_model (
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  input wire logic so_o,
  input wire logic so_oe
);
  // Idle level of sck picks mode 0,0 or 1,1, nothing else
  logic idle_hi = 1'h0;

  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
    hold_n = 1'h1;
  end

  ////////////////////////////////////////
  // Bits leave and arrive most significant first
  task automatic xfer(input logic [7:0] tx, input int hold_at, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'h0;
      si = tx[i];
      if (i == hold_at) begin
        hold_n = 1'h0;
        repeat (2) begin
          #62.5 sck = 1'h1;
          si = ~si;
          #62.5 sck = 1'h0;
        end
        si = tx[i];
        hold_n = 1'h1;
      end
      #62.5 sck = 1'h1;
      rx[i] = (so_oe === 1'h1) ? so_o : 1'hx;
      #62.5;
    end
  endtask

  task automatic frame(input logic [7:0] tx[$], input int n_rd, input int hold_at, output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    // Clock settles at its idle level before select, so no false edge
    sck = idle_hi;
    #100;
    // Select held low for the whole frame; hold drops only inside the first byte, at bit hold_at
    cs_n = 1'h0;
    #100;
    foreach (tx[k]) xfer(tx[k], (k == 0) ? hold_at : -1, b);
    repeat (n_rd) begin
      xfer(8'h00, -1, b);
      rx.push_back(b);
    end
    sck = idle_hi;
    #100;
    cs_n = 1'h1;
    // A released line must not keep showing the last bit
    si = ~si;
    #400;
  endtask

  // Clocks only the top n bits of tx, then deselects mid byte
  task automatic cut(input logic [7:0] tx, input int n);
    sck = idle_hi;
    #100;
    cs_n = 1'h0;
    #100;
    for (int i = 7; i > 7 - n; i--) begin
      sck = 1'h0;
      si = tx[i];
      #62.5 sck = 1'h1;
      #62.5;
    end
    sck = idle_hi;
    #100;
    cs_n = 1'h1;
    si = ~si;
    #400;
  endtask
endmodule // ssec_host_model
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int WR_CYC = 400;
  logic mclk, sys_rst, protect_pin_n, sck, cs_n, si, hold_n, so_o, so_oe;
  int errors = 0;
  int n_compared = 0;
  logic [7:0] rx[$];
  logic [15:0] base[4] = '{16'h0000, 16'h0c00, 16'h0800, 16'h0000};

  ssec_eeprom #(.WR_CYCLES(WR_CYC), .FIFO_DEPTH(2)) dut (.mclk(mclk), .sys_rst(sys_rst), .sck(sck),
    .cs_n(cs_n), .si(si), .hold_n(hold_n), .protect_pin_n(protect_pin_n), .so_o(so_o), .so_oe(so_oe));
  ssec_host_model u_host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_o(so_o), .so_oe(so_oe));

  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end

  ////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [7:0] tx[$], input int n_rd);
    u_host.frame(tx, n_rd, -1, rx);
  endtask

  task automatic status(input logic [7:0] exp);
    send('{ssec_pkg::OP_STAT_RD}, 1);
    check(rx[0], exp);
  endtask

  // Fixed wait covers one whole self-timed cycle
  task automatic settle();
    #(WR_CYC * 8 + 1000);
  endtask

  task automatic arr_wr(input logic [15:0] a, input logic [7:0] d[$]);
    logic [7:0] q[$];
    q = {ssec_pkg::OP_ARR_WR, a[15:8], a[7:0], d};
    send('{ssec_pkg::OP_LATCH_SET}, 0);
    send(q, 0);
  endtask

  task automatic sr_wr(input logic [7:0] v);
    send('{ssec_pkg::OP_LATCH_SET}, 0);
    send('{ssec_pkg::OP_STAT_WR, v}, 0);
    settle();
  endtask

  ////////////////////////////////////////
  task automatic t_reset();
    check({7'h00, so_oe}, 8'h00);
    status(8'h00);
  endtask

  task automatic t_latch();
    u_host.frame('{ssec_pkg::OP_LATCH_SET}, 0, 3, rx);
    status(8'h02);
    send('{ssec_pkg::OP_LATCH_CLR}, 0);
    status(8'h00);
    send('{ssec_pkg::OP_LATCH_SET, 8'h00}, 0);
    status(8'h00);
    u_host.cut(ssec_pkg::OP_LATCH_SET, 7);
    status(8'h00);
    send('{ssec_pkg::OP_ARR_WR, 8'h00, 8'h00, 8'h5a}, 0);
    status(8'h00);
  endtask

  task automatic t_page();
    arr_wr(16'hffff, '{8'ha1, 8'hb2, 8'hc3});
    status(8'h03);
    settle();
    status(8'h00);
    arr_wr(16'h0000, '{8'hd4});
    settle();
    send('{ssec_pkg::OP_ARR_RD, 8'hff, 8'hff}, 2);
    check(rx[0], 8'ha1);
    check(rx[1], 8'hd4);
    send('{ssec_pkg::OP_ARR_RD, 8'h0f, 8'he0}, 2);
    check(rx[0], 8'hb2);
    check(rx[1], 8'hc3);
  endtask

  task automatic t_guard();
    for (int g = 1; g < 4; g++) begin
      sr_wr({4'h0, g[1:0], 2'h0});
      status({4'h0, g[1:0], 2'h0});
      arr_wr(base[g], '{8'h11});
      status({4'h0, g[1:0], 2'h2});
      send('{ssec_pkg::OP_LATCH_CLR}, 0);
      if (g < 3) begin
        arr_wr(base[g] - 16'h0001, '{8'h22});
        status({4'h0, g[1:0], 2'h3});
        settle();
      end
    end
  endtask

  task automatic t_pin();
    sr_wr(8'h80);
    @(posedge mclk);
    #1;
    protect_pin_n = 1'h0;
    sr_wr(8'h0c);
    status(8'h82);
    arr_wr(16'h0100, '{8'h33});
    status(8'h83);
    settle();
    @(posedge mclk);
    #1;
    protect_pin_n = 1'h1;
    sr_wr(8'h00);
    status(8'h00);
  endtask

  task automatic t_mode();
    u_host.idle_hi = 1'h1;
    send('{ssec_pkg::OP_LATCH_SET}, 0);
    status(8'h02);
    send('{ssec_pkg::OP_LATCH_CLR}, 0);
    u_host.idle_hi = 1'h0;
    status(8'h00);
  endtask

  ////////////////////////////////////////
  task automatic end_of_test();
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'h1;
    protect_pin_n = 1'h1;
    repeat (8) @(posedge mclk);
    #1;
    sys_rst = 1'h0;
    repeat (3) @(posedge mclk);
    t_reset();
    t_latch();
    t_page();
    t_guard();
    t_pin();
    t_mode();
    end_of_test();
  end

  // Normal run is near 215 us; the 600 us limit, near three times that, means a hang
  initial begin
    #600000;
    errors++;
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
